//--- hw/std_timer_regs.svh
// Register offsets, field positions, reset values for the standard timer.
// Assumes a 32-bit APB slave, one register per aligned word.
`ifndef STD_TIMER_REGS_SVH
`define STD_TIMER_REGS_SVH

`define RUN_CTRL_OFS     12'h000
`define MODE_CTRL_OFS    12'h004
`define CNT_LO_OFS       12'h008
`define CNT_HI_OFS       12'h00c
`define CMPA_LO_OFS      12'h010
`define CMPA_HI_OFS      12'h014
`define CMPP_OFS         12'h018

`define RUN_EN_BIT       3
`define MODE_MSB         7
`define MODE_LSB         6
`define PINF_MSB         5
`define PINF_LSB         4
`define INIT_LVL_BIT     3
`define INVERT_BIT       2
`define SWAP_BIT         1
`define CLR_SEL_BIT      0

`define RUN_CTRL_RST     8'h00
`define MODE_CTRL_RST    8'h00
`define RUN_CTRL_MASK    8'h08

`endif

//--- hw/std_timer_pkg.sv
// Types for the standard timer.
// Assumes the register header is included by the design file.
package std_timer_pkg;
   typedef enum logic [1:0] {
      MODE_COMPARE = 2'b00,
      MODE_CAPTURE = 2'b01,
      MODE_PWM     = 2'b10,
      MODE_TIMER   = 2'b11
   } op_mode_t;

   typedef struct packed {
      op_mode_t   mode;
      logic [1:0] pin_func;
      logic       init_level;
      logic       invert;
      logic       swap;
      logic       clear_sel;
   } mode_ctrl_t;
endpackage

//--- hw/std_timer.sv
// Standard 16-bit timer: run control, mode control, counter and compare A/P.
// Assumes an APB master on clk and a timer pin synchronous to clk.
// What this block does
// - Run enable rising edge clears the counter and starts counting.
// - Run enable falling holds the counter value and stops the timer.
// - Run enable rise resets pin to initial level in compare/PWM/pulse modes.
// - Run control bits two to zero read as zero.
// - Mode field: 00 compare, 01 capture, 10 PWM/pulse, 11 timer.
// - Timer mode ignores pin function, level and invert bits.
// - Compare mode on A match: keep, low, high or toggle the pin.
// - PWM mode pin: inactive, active, PWM, single pulse.
// - Capture mode: rising, falling, both edges, or disabled.
// - Requested level equal to pin level shows no change.
// - Initial level bit sets start level or PWM active level.
// - Invert bit inverts the output pin.
// - Swap bit exchanges period and duty compare roles.
// - Clear select: 1 clears on A match, 0 on P match/overflow.
// - Overflow clearing only when compare P is all zero.
// - Clear select ignored in PWM, pulse and capture modes.
// - Counter read as two read-only bytes, reset zero.
// - Compare A held in two read/write bytes, reset zero.
// - Low byte goes via shared buffer; high byte access moves it.
// - Comparator P matches upper eight counter bits with the low byte zero; A uses all sixteen.
`include "std_timer_regs.svh"

module std_timer
   import std_timer_pkg::*;
#(
   parameter int CNT_W = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Counter clock enable
   input wire logic cnt_tick,
   // Timer pin
   input wire logic timer_io_pin_in,
   output logic timer_io_pin_out,
   output logic timer_io_pin_oe,
   // Events
   output logic match_a,
   output logic match_p,
   output logic capture
);

   initial begin
      if (CNT_W != 16) begin
         $error("std_timer supports only a 16-bit counter");
      end
   end

   logic [7:0] run_ctrl_ff;
   mode_ctrl_t mode_ff;
   logic [15:0] cnt_ff;
   logic [15:0] cmpa_ff;
   logic [7:0] cmpp_ff;
   logic [7:0] buf_ff;
   logic run_d_ff;
   logic pin_ff;
   logic pin_in_d_ff;
   logic pulse_done_ff;
   logic [31:0] prdata_ff;
   logic pslverr_ff;
   logic match_a_ff;
   logic match_p_ff;
   logic capture_ff;
   logic pready_ff;

   // Byte address match for one register
   function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] ofs);
      reg_hit = (addr == ofs);
   endfunction

   // Compare P as a counter span; zero stands for the full range
   function automatic logic [16:0] p_span(input logic [7:0] p);
      if (p == 8'h00) begin
         p_span = 17'h10000;
      end else begin
         p_span = {1'b0, p, 8'h00};
      end
   endfunction

   // Bus decode: read data is prepared in the setup cycle, while a write
   // lands only at the access edge at which pready is seen high
   wire setup = psel && !penable;
   wire access = psel && penable && pready_ff;
   wire wr = access && pwrite;
   wire rd = setup && !pwrite;
   wire sel_run = reg_hit(paddr, `RUN_CTRL_OFS);
   wire sel_mode = reg_hit(paddr, `MODE_CTRL_OFS);
   wire sel_clo = reg_hit(paddr, `CNT_LO_OFS);
   wire sel_chi = reg_hit(paddr, `CNT_HI_OFS);
   wire sel_alo = reg_hit(paddr, `CMPA_LO_OFS);
   wire sel_ahi = reg_hit(paddr, `CMPA_HI_OFS);
   wire sel_p = reg_hit(paddr, `CMPP_OFS);
   wire mapped = sel_run | sel_mode | sel_clo | sel_chi | sel_alo | sel_ahi | sel_p;

   wire run = run_ctrl_ff[`RUN_EN_BIT];
   wire run_rise = run && !run_d_ff;
   wire is_cmp = (mode_ff.mode == MODE_COMPARE);
   wire is_tmr = (mode_ff.mode == MODE_TIMER);
   wire is_pwm = (mode_ff.mode == MODE_PWM);
   wire is_cap = (mode_ff.mode == MODE_CAPTURE);

   // Comparator widths
   wire a_hit = (cnt_ff == cmpa_ff);
   wire p_hit = (cmpp_ff != 8'h00) && (cnt_ff[15:8] == cmpp_ff) && (cnt_ff[7:0] == 8'h00);
   wire ovf = (cnt_ff == 16'hffff);
   wire step = run && cnt_tick;

   // Period and duty selection
   wire [16:0] p_full = p_span(cmpp_ff);
   wire [16:0] period = mode_ff.swap ? {1'b0, cmpa_ff} : p_full;
   wire [16:0] duty = mode_ff.swap ? p_full : {1'b0, cmpa_ff};
   wire [16:0] cnt_nxt1 = {1'b0, cnt_ff} + 17'h00001;
   wire pwm_end = (cnt_nxt1 >= period);
   wire pwm_active = ({1'b0, cnt_ff} < duty);

   // Clear selection
   wire clr_cmp = mode_ff.clear_sel ? a_hit : (p_hit || ((cmpp_ff == 8'h00) && ovf));
   wire clr_pwm = pwm_end;
   wire cnt_clr = (is_pwm || is_cap) ? (is_pwm && clr_pwm) : clr_cmp;

   logic [15:0] nxt_cnt;
   always_comb begin
      nxt_cnt = cnt_ff;
      if (run_rise) begin
         nxt_cnt = 16'h0000;
      end else if (step) begin
         if (cnt_clr) begin
            nxt_cnt = 16'h0000;
         end else begin
            nxt_cnt = cnt_nxt1[15:0];
         end
      end
   end

   // Output level before inversion
   logic nxt_pin;
   always_comb begin
      nxt_pin = pin_ff;
      if (run_rise) begin
         nxt_pin = mode_ff.init_level;
      end else if (is_cmp && step && a_hit) begin
         case (mode_ff.pin_func)
            2'b00: nxt_pin = pin_ff;
            2'b01: nxt_pin = 1'b0;
            2'b10: nxt_pin = 1'b1;
            2'b11: nxt_pin = !pin_ff;
            default: nxt_pin = pin_ff;
         endcase
      end else if (is_pwm && run) begin
         case (mode_ff.pin_func)
            2'b00: nxt_pin = !mode_ff.init_level;
            2'b01: nxt_pin = mode_ff.init_level;
            2'b10: nxt_pin = pwm_active ? mode_ff.init_level : !mode_ff.init_level;
            2'b11: nxt_pin = (pwm_active && !pulse_done_ff) ?
                             mode_ff.init_level : !mode_ff.init_level;
            default: nxt_pin = pin_ff;
         endcase
      end
   end

   wire pulse_end = is_pwm && (mode_ff.pin_func == 2'b11) && step && !pwm_active;

   wire pin_rise = timer_io_pin_in && !pin_in_d_ff;
   wire pin_fall = !timer_io_pin_in && pin_in_d_ff;
   wire cap_hit = is_cap && run && ((mode_ff.pin_func == 2'b00 && pin_rise) ||
                  (mode_ff.pin_func == 2'b01 && pin_fall) ||
                  (mode_ff.pin_func == 2'b10 && (pin_rise || pin_fall)));

   wire buf_load_cnt = rd && sel_chi;
   wire buf_load_a = rd && sel_ahi;
   wire buf_wr = wr && (sel_alo || sel_clo);
   logic [7:0] nxt_buf;
   always_comb begin
      if (buf_wr) begin
         nxt_buf = pwdata[7:0];
      end else if (buf_load_cnt) begin
         nxt_buf = cnt_ff[7:0];
      end else if (buf_load_a) begin
         nxt_buf = cmpa_ff[7:0];
      end else begin
         nxt_buf = buf_ff;
      end
   end

   logic [7:0] rd_byte;
   always_comb begin
      if (sel_run) begin
         rd_byte = run_ctrl_ff & `RUN_CTRL_MASK;
      end else if (sel_mode) begin
         rd_byte = mode_ff;
      end else if (sel_clo || sel_alo) begin
         rd_byte = buf_ff;
      end else if (sel_chi) begin
         rd_byte = cnt_ff[15:8];
      end else if (sel_ahi) begin
         rd_byte = cmpa_ff[15:8];
      end else if (sel_p) begin
         rd_byte = cmpp_ff;
      end else begin
         rd_byte = 8'h00;
      end
   end

   wire pin_drive = mode_ff.invert ? !pin_ff : pin_ff;
   wire pin_oe = !is_tmr && !is_cap;

   // Control registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         run_ctrl_ff <= `RUN_CTRL_RST;
         mode_ff <= `MODE_CTRL_RST;
      end else begin
         if (wr && sel_run) begin
            run_ctrl_ff <= pwdata[7:0] & `RUN_CTRL_MASK;
         end
         if (wr && sel_mode) begin
            mode_ff <= pwdata[7:0];
         end
      end
   end

   // Compare values and the shared low-byte buffer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cmpa_ff <= 16'h0000;
         cmpp_ff <= 8'h00;
         buf_ff <= 8'h00;
      end else begin
         buf_ff <= nxt_buf;
         if (wr && sel_ahi) begin
            cmpa_ff <= {pwdata[7:0], buf_ff};
         end
         if (wr && sel_p) begin
            cmpp_ff <= pwdata[7:0];
         end
      end
   end

   // Counter, pin level and input history
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= 16'h0000;
         run_d_ff <= 1'b0;
         pin_ff <= 1'b0;
         pin_in_d_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         run_d_ff <= run;
         pin_ff <= nxt_pin;
         pin_in_d_ff <= timer_io_pin_in;
      end
   end

   // A single pulse stays spent until the next start
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pulse_done_ff <= 1'b0;
      end else begin
         pulse_done_ff <= run_rise ? 1'b0 : (pulse_done_ff | pulse_end);
      end
   end

   // Bus answer: no wait state; the error flag stands only with pready
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata_ff <= 32'h00000000;
         pslverr_ff <= 1'b0;
         pready_ff <= 1'b0;
      end else begin
         if (rd) begin
            prdata_ff <= {24'h000000, rd_byte};
         end
         pslverr_ff <= setup && !mapped;
         pready_ff <= setup;
      end
   end

   // Event pulses
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         match_a_ff <= 1'b0;
         match_p_ff <= 1'b0;
         capture_ff <= 1'b0;
      end else begin
         match_a_ff <= step && a_hit && !run_rise;
         match_p_ff <= step && p_hit && !run_rise && !(is_cmp && mode_ff.clear_sel);
         capture_ff <= cap_hit;
      end
   end

   // Pin outputs
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         timer_io_pin_out <= 1'b0;
         timer_io_pin_oe <= 1'b0;
      end else begin
         timer_io_pin_out <= pin_drive;
         timer_io_pin_oe <= pin_oe;
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign match_a = match_a_ff;
   assign match_p = match_p_ff;
   assign capture = capture_ff;

endmodule

//--- verification/std_timer_assertions.sv
// Port checker for the standard timer.
// Assumes one clock domain; bound to every std_timer instance.
module std_timer_assertions (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Pin
   input wire logic timer_io_pin_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire logic setup = psel && !penable;
   wire logic mode_wr = setup && pwrite && paddr == 12'h004;
   ready_after_setup_a:
      assert property (setup |=> pready) else $error("no ready after setup");
   no_stray_ready_a:
      assert property (!psel |=> !pready) else $error("ready without request");
   err_with_ready_a:
      assert property (pslverr |-> pready) else $error("error without ready");
   unmapped_err_a:
      assert property (setup && paddr > 12'h018 |=> pslverr) else $error("unmapped accepted");
   run_low_zero_a:
      assert property (setup && !pwrite && paddr == 12'h000 |=> prdata[2:0] == 3'h0)
         else $error("run control low bits set");
   upper_zero_a:
      assert property (pready |-> prdata[31:8] == 24'h0) else $error("read upper bits set");
   oe_off_a:
      assert property (mode_wr && pwdata[6] |-> ##[1:3] !timer_io_pin_oe) else $error("pin on");
   oe_on_a:
      assert property (mode_wr && !pwdata[6] |-> ##[1:3] timer_io_pin_oe) else $error("pin off");
endmodule

bind std_timer std_timer_assertions u_std_timer_assertions (.clk, .rst_n, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .timer_io_pin_oe);

//--- verification/timer_pin_model.sv
// Party outside the timer pin.
// Assumes the pin is driven by the timer only while it enables it.
module timer_pin_model (
   // Timer side
   input wire logic pin_out,
   input wire logic pin_oe,
   // Bench side
   input wire logic ext_level,
   output logic pin_in
);
   timeunit 1ns;
   timeprecision 1ps;
   assign pin_in = pin_oe ? pin_out : ext_level;
endmodule

//--- verification/standard_timer_control_bench.sv
// Self-checking bench for the standard timer.
// Assumes the port checker is bound and the pin model sits on the pin.
`include "std_timer_regs.svh"
module standard_timer_control_bench import std_timer_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'h0;
   logic rst_n, psel, penable, pwrite, cnt_tick, ext_level, cap, cap_seen, err;
   logic pready, pslverr, pin_in, pin_out, pin_oe;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [9:0] pin_tab [6] = '{10'h004, 10'h066, 10'h085, 10'h0c5, 10'h096, 10'h044};
   int fail_count = 0;
   int n_tests = 0;
   std_timer u_std_timer (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .cnt_tick, .timer_io_pin_in(pin_in), .timer_io_pin_out(pin_out),
      .timer_io_pin_oe(pin_oe), .match_a(), .match_p(), .capture(cap));
   timer_pin_model u_timer_pin_model (.pin_out, .pin_oe, .ext_level, .pin_in);
   initial forever #5 clk = ~clk;
   always @(posedge clk) if (cap === 1'h1) cap_seen <= 1'h1;
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      {psel, pwrite, paddr, pwdata} <= {1'h1, wr, a, d};
      @(posedge clk);
      penable <= 1'h1;
      do @(posedge clk); while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'h0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'h1, a, {24'h0, d});
   endtask
   task automatic rchk(input string w, input logic [11:0] a, input logic [7:0] e);
      apb(1'h0, a, 32'h0);
      check(w, rd, {24'h0, e});
   endtask
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge clk);
         cnt_tick <= 1'h1;
         @(posedge clk);
         cnt_tick <= 1'h0;
      end
      repeat (3) @(posedge clk);
   endtask
   task automatic start(input logic [7:0] mode);
      wr(`RUN_CTRL_OFS, 8'h00);
      wr(`MODE_CTRL_OFS, mode);
      wr(`RUN_CTRL_OFS, 8'h08);
      repeat (3) @(posedge clk);
   endtask
   task automatic t_regs;
      rchk("mode", `MODE_CTRL_OFS, 8'h00);
      rchk("cnt_hi", `CNT_HI_OFS, 8'h00);
      rchk("cnt_lo", `CNT_LO_OFS, 8'h00);
      wr(`RUN_CTRL_OFS, 8'hf7);
      rchk("run", `RUN_CTRL_OFS, 8'h00);
      apb(1'h0, 12'h01c, 32'h0);
      wr(`CMPA_LO_OFS, 8'h34);
      rchk("a_hi", `CMPA_HI_OFS, 8'h00);
      rchk("a_lo", `CMPA_LO_OFS, 8'h00);
      wr(`CMPA_LO_OFS, 8'h34);
      wr(`CMPA_HI_OFS, 8'h12);
      rchk("a_hi", `CMPA_HI_OFS, 8'h12);
      rchk("a_lo", `CMPA_LO_OFS, 8'h34);
      $display("test regs done");
   endtask
   task automatic t_count;
      wr(`RUN_CTRL_OFS, 8'hff);
      rchk("run", `RUN_CTRL_OFS, 8'h08);
      tick(5);
      wr(`RUN_CTRL_OFS, 8'h00);
      tick(2);
      rchk("cnt_hi", `CNT_HI_OFS, 8'h00);
      rchk("cnt_lo", `CNT_LO_OFS, 8'h05);
      wr(`RUN_CTRL_OFS, 8'h08);
      tick(1);
      rchk("cnt_hi", `CNT_HI_OFS, 8'h00);
      rchk("cnt_lo", `CNT_LO_OFS, 8'h01);
      $display("test count done");
   endtask
   task automatic t_pin;
      wr(`CMPA_LO_OFS, 8'h03);
      wr(`CMPA_HI_OFS, 8'h00);
      for (int i = 0; i < 6; i++) begin
         start(pin_tab[i][9:2]);
         check("pin_start", {31'h0, pin_out}, {31'h0, pin_tab[i][1]});
         tick(4);
         check("pin_match", {31'h0, pin_out}, {31'h0, pin_tab[i][0]});
      end
      $display("test pin done");
   endtask
   task automatic t_cap;
      for (int i = 0; i < 4; i++) begin
         ext_level <= 1'h0;
         start({2'b01, i[1:0], 4'h0});
         cap_seen = 1'h0;
         ext_level <= 1'h1;
         repeat (4) @(posedge clk);
         check("capture", {31'h0, cap_seen}, {31'h0, ~i[0]});
      end
      $display("test capture done");
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #100us;
      fail_count++;
      stop_test;
   end
   initial begin
      {psel, penable, pwrite, cnt_tick, ext_level, rst_n, cap_seen} = 7'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      repeat (6) @(posedge clk);
      rst_n <= 1'h1;
      t_regs;
      t_count;
      t_pin;
      t_cap;
      stop_test;
   end
endmodule
